//--- inc/agc_consts.svh
// Constants, register map and timing figures for the gain control block
`ifndef AGC_CONSTS_SVH
`define AGC_CONSTS_SVH
`define AGC_CLK_NS 8
`define AGC_TICK_NS 1000
`define AGC_ADDR_W 8
`define AGC_OFF_CTRL 8'h00
`define AGC_OFF_FIXED 8'h04
`define AGC_OFF_MAXG 8'h08
`define AGC_OFF_LIMIT 8'h0c
`define AGC_OFF_GATE 8'h10
`define AGC_OFF_RATIO 8'h14
`define AGC_OFF_ATTACK 8'h18
`define AGC_OFF_RELEASE 8'h1c
`define AGC_OFF_HOLD 8'h20
`define AGC_OFF_STATUS 8'h24
`define AGC_CTRL_RST 5'h10
`define AGC_FIXED_RST 6'h06
`define AGC_GAIN_RST 8'h0c
`define AGC_MAXG_RST 6'h1e
`define AGC_LIMIT_RST 8'ha0
`define AGC_GATE_RST 8'h10
`define AGC_RATIO_RST 2'h1
`define AGC_ATTACK_RST 16'h0010
`define AGC_RELEASE_RST 16'h0400
`define AGC_HOLD_RST 16'h0800
`define AGC_FIXED_LO_COMP 8'she4
`define AGC_FIXED_LO_LIN 8'sh00
`define AGC_FIXED_HI 8'sh1e
`define AGC_GAIN_MIN 11'sh7c8
`define AGC_ROT_LEVEL 11'sh096
`define AGC_DEADBAND 11'sh001
`define AGC_STEP 8'sh01
`define AGC_DECAY_SH 4'h8
`define AGC_LOG_BIT 8'h0c
`define AGC_LOG_FRAC 8'h03
`endif

//--- inc/agc_pkg.sv
// Types shared by the gain control block
`default_nettype none
package agc_pkg;
    // Level and gain arithmetic in half-dB units
    typedef logic signed [10:0] agc_lvl_t;
    // Working mode of the gain steering
    typedef enum logic [1:0] {AGC_SHUTDOWN, AGC_FIXED, AGC_TRACK} agc_state_e;
    // Programmed settings as one bundle
    typedef struct packed {
        logic agc_en;
        logic comp_en;
        logic lim_en;
        logic hold_en;
        logic shdn;
        logic signed [5:0] fixed;
        logic signed [5:0] maxg;
        logic [7:0] limit;
        logic [7:0] gate;
        logic [1:0] ratio;
        logic [15:0] attack;
        logic [15:0] release_t;
        logic [15:0] hold;
    } agc_cfg_s;
endpackage
`default_nettype wire

//--- rtl/agc_step_timer.sv
// Elapsed time since the last gain step, shared by all three intervals
`timescale 1ns/100ps
`default_nettype none
`include "agc_consts.svh"
module agc_step_timer #(
    parameter int TICK_CYCLES = `AGC_TICK_NS / `AGC_CLK_NS,
    parameter int EL_W = 17
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic restart,
    input wire logic expire,
    output logic [EL_W-1:0] elapsed
);
    localparam int PS_W = $clog2(TICK_CYCLES + 1);
    logic [PS_W-1:0] pre_reg; // Divider to one time unit
    logic [EL_W-1:0] elapsed_reg; // Saturating unit count
    logic tick; // One time unit passed

    assign tick = (pre_reg == PS_W'(TICK_CYCLES - 1));
    assign elapsed = elapsed_reg;

    // Prescaler, realigned on every step
    always_ff @(posedge clk) begin
        if (reset || restart || tick) begin
            pre_reg <= '0;
        end else begin
            pre_reg <= pre_reg + 1'b1;
        end
    end

    // Count units; starts expired so a first step is not delayed
    always_ff @(posedge clk) begin
        if (reset || expire) begin
            elapsed_reg <= '1;
        end else if (restart) begin
            elapsed_reg <= '0;
        end else if (tick && (elapsed_reg != '1)) begin
            elapsed_reg <= elapsed_reg + 1'b1;
        end
    end
endmodule
`default_nettype wire

//--- rtl/agc_env_det.sv
// Input envelope detector with a coarse log level in half-dB units
`timescale 1ns/100ps
`default_nettype none
`include "agc_consts.svh"
module agc_env_det #(
    parameter int SMP_W = 16
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic smp_valid,
    input wire logic signed [SMP_W-1:0] smp_data,
    output logic [7:0] level
);
    logic [SMP_W-1:0] mag; // Sample magnitude
    logic [SMP_W-1:0] env_reg; // Peak envelope
    logic [SMP_W-1:0] norm; // Envelope with top bit at msb
    logic [7:0] level_reg;
    logic [7:0] level_next;
    int pos; // Position of leading one

    assign mag = smp_data[SMP_W-1] ? SMP_W'(-smp_data) : SMP_W'(smp_data);
    assign level = level_reg;

    // Fast rise to peaks, slow exponential decay
    always_ff @(posedge clk) begin
        if (reset) begin
            env_reg <= '0;
        end else if (smp_valid) begin
            if (mag > env_reg) begin
                env_reg <= mag;
            end else begin
                env_reg <= env_reg - (env_reg >> `AGC_DECAY_SH);
            end
        end
    end

    // Log: 6 dB per bit, two mantissa bits refine it
    always_comb begin
        pos = 0;
        for (int i = 0; i < SMP_W; i++) begin
            if (env_reg[i]) begin
                pos = i;
            end
        end
        norm = env_reg << (SMP_W - 1 - pos);
        if (env_reg == '0) begin
            level_next = '0;
        end else begin
            level_next = 8'((pos + 1) * `AGC_LOG_BIT + norm[SMP_W-2 -: 2] * `AGC_LOG_FRAC);
        end
    end

    // Registered level
    always_ff @(posedge clk) begin
        if (reset) begin
            level_reg <= '0;
        end else begin
            level_reg <= level_next;
        end
    end
endmodule
`default_nettype wire

//--- rtl/agc_core.sv
// Gain control core: register port, gain steering and step timing
`timescale 1ns/100ps
`default_nettype none
`include "agc_consts.svh"
module agc_core #(
    parameter int SMP_W = 16,
    parameter int TICK_CYCLES = `AGC_TICK_NS / `AGC_CLK_NS
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [`AGC_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic smp_valid,
    input wire logic signed [SMP_W-1:0] smp_data,
    output logic signed [7:0] gain_half,
    output logic gain_up,
    output logic gain_dn,
    output logic agc_active
);
    localparam int EL_W = 17;

    // Setting registers
    logic [4:0] ctrl_reg; // Enables and shutdown
    logic signed [5:0] fixed_reg; // Fixed gain, dB
    logic signed [5:0] maxg_reg; // Maximum gain, dB
    logic [7:0] limit_reg; // Limiter output level
    logic [7:0] gate_reg; // Noise gate level
    logic [1:0] ratio_reg; // Log2 of compression ratio
    logic [15:0] attack_reg;
    logic [15:0] release_reg;
    logic [15:0] hold_reg;
    agc_pkg::agc_cfg_s cfg; // Bundled view of settings

    // Steering state
    agc_pkg::agc_state_e state_reg;
    agc_pkg::agc_state_e state_next;
    logic signed [7:0] gain_reg; // Working gain, half-dB
    logic gain_up_reg;
    logic gain_dn_reg;
    logic active_reg;
    logic after_dec_reg; // Last step was a decrement
    logic [31:0] rdata_reg;

    // Decision signals
    logic [7:0] level; // Envelope level, half-dB
    logic [EL_W-1:0] elapsed; // Units since last step
    logic signed [7:0] wr_gain;
    logic signed [7:0] fixed_lo;
    logic signed [7:0] fixed_clip;
    logic signed [7:0] maxg_clip;
    logic signed [5:0] fixed_eff;
    agc_pkg::agc_lvl_t lvl, fixed_h, max_h, gain_x;
    agc_pkg::agc_lvl_t dl, comp_t, lim_t, target;
    logic [15:0] up_iv; // Interval gating next increment
    logic tracking, gated, over_lim;
    logic dec_want, inc_want, step_dn, step_up;

    assign cfg = '{agc_en: ctrl_reg[0], comp_en: ctrl_reg[1], lim_en: ctrl_reg[2],
                   hold_en: ctrl_reg[3], shdn: ctrl_reg[4], fixed: fixed_reg,
                   maxg: maxg_reg, limit: limit_reg, gate: gate_reg, ratio: ratio_reg,
                   attack: attack_reg, release_t: release_reg, hold: hold_reg};

    // Outputs straight from flip-flops
    assign reg_rdata = rdata_reg;
    assign gain_half = gain_reg;
    assign gain_up = gain_up_reg;
    assign gain_dn = gain_dn_reg;
    assign agc_active = active_reg;

    // Envelope of the audio input feeds every decision
    agc_env_det #(.SMP_W(SMP_W)) u_env (
        .clk(clk),
        .reset(reset),
        .smp_valid(smp_valid),
        .smp_data(smp_data),
        .level(level)
    );

    // One elapsed count serves attack, release and hold
    agc_step_timer #(.TICK_CYCLES(TICK_CYCLES), .EL_W(EL_W)) u_timer (
        .clk(clk),
        .reset(reset),
        .restart(step_dn || step_up),
        .expire(!tracking),
        .elapsed(elapsed)
    );

    // Clamp written gains; the fixed gain span follows the mode, the maximum gain span does not
    assign wr_gain = reg_wdata[7:0];
    assign fixed_lo = cfg.comp_en ? `AGC_FIXED_LO_COMP : `AGC_FIXED_LO_LIN;
    always_comb begin
        if (wr_gain < fixed_lo) begin
            fixed_clip = fixed_lo;
        end else if (wr_gain > `AGC_FIXED_HI) begin
            fixed_clip = `AGC_FIXED_HI;
        end else begin
            fixed_clip = wr_gain;
        end
        if (wr_gain < `AGC_FIXED_LO_COMP) begin
            maxg_clip = `AGC_FIXED_LO_COMP;
        end else if (wr_gain > `AGC_FIXED_HI) begin
            maxg_clip = `AGC_FIXED_HI;
        end else begin
            maxg_clip = wr_gain;
        end
    end

    // Control register
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_reg <= `AGC_CTRL_RST;
        end else if (reg_wr && (reg_addr == `AGC_OFF_CTRL)) begin
            ctrl_reg <= reg_wdata[4:0];
        end
    end

    // Gain settings, stored already clamped
    always_ff @(posedge clk) begin
        if (reset) begin
            fixed_reg <= `AGC_FIXED_RST;
            maxg_reg <= `AGC_MAXG_RST;
        end else if (reg_wr && (reg_addr == `AGC_OFF_FIXED)) begin
            fixed_reg <= fixed_clip[5:0];
        end else if (reg_wr && (reg_addr == `AGC_OFF_MAXG)) begin
            maxg_reg <= maxg_clip[5:0];
        end
    end

    // Level settings
    always_ff @(posedge clk) begin
        if (reset) begin
            limit_reg <= `AGC_LIMIT_RST;
            gate_reg <= `AGC_GATE_RST;
            ratio_reg <= `AGC_RATIO_RST;
        end else if (reg_wr) begin
            if (reg_addr == `AGC_OFF_LIMIT) begin
                limit_reg <= reg_wdata[7:0];
            end
            if (reg_addr == `AGC_OFF_GATE) begin
                gate_reg <= reg_wdata[7:0];
            end
            if (reg_addr == `AGC_OFF_RATIO) begin
                ratio_reg <= reg_wdata[1:0];
            end
        end
    end

    // Interval settings in time units
    always_ff @(posedge clk) begin
        if (reset) begin
            attack_reg <= `AGC_ATTACK_RST;
            release_reg <= `AGC_RELEASE_RST;
            hold_reg <= `AGC_HOLD_RST;
        end else if (reg_wr) begin
            if (reg_addr == `AGC_OFF_ATTACK) begin
                attack_reg <= reg_wdata[15:0];
            end
            if (reg_addr == `AGC_OFF_RELEASE) begin
                release_reg <= reg_wdata[15:0];
            end
            if (reg_addr == `AGC_OFF_HOLD) begin
                hold_reg <= reg_wdata[15:0];
            end
        end
    end

    // Read data stand one cycle, zero otherwise
    always_ff @(posedge clk) begin
        if (reset || !reg_rd) begin
            rdata_reg <= '0;
        end else begin
            case (reg_addr)
                `AGC_OFF_CTRL: rdata_reg <= {27'h0, ctrl_reg};
                `AGC_OFF_FIXED: rdata_reg <= {{26{fixed_reg[5]}}, fixed_reg};
                `AGC_OFF_MAXG: rdata_reg <= {{26{maxg_reg[5]}}, maxg_reg};
                `AGC_OFF_LIMIT: rdata_reg <= {24'h0, limit_reg};
                `AGC_OFF_GATE: rdata_reg <= {24'h0, gate_reg};
                `AGC_OFF_RATIO: rdata_reg <= {30'h0, ratio_reg};
                `AGC_OFF_ATTACK: rdata_reg <= {16'h0, attack_reg};
                `AGC_OFF_RELEASE: rdata_reg <= {16'h0, release_reg};
                `AGC_OFF_HOLD: rdata_reg <= {16'h0, hold_reg};
                `AGC_OFF_STATUS: rdata_reg <= {13'h0, tracking, over_lim, gated,
                                               level, gain_reg};
                default: rdata_reg <= '0;
            endcase
        end
    end

    // Without compression a negative fixed gain acts as 0 dB
    assign fixed_eff = (!cfg.comp_en && cfg.fixed[5]) ? 6'h00 : cfg.fixed;
    assign fixed_h = agc_pkg::agc_lvl_t'({{4{fixed_eff[5]}}, fixed_eff, 1'b0});
    assign max_h = agc_pkg::agc_lvl_t'({{4{cfg.maxg[5]}}, cfg.maxg, 1'b0});
    assign gain_x = agc_pkg::agc_lvl_t'({{3{gain_reg[7]}}, gain_reg});
    assign lvl = agc_pkg::agc_lvl_t'({3'h0, level});

    // Target gain from compression curve and limiter
    always_comb begin
        dl = `AGC_ROT_LEVEL - lvl;
        // Gain moves by (1 - 1/N) of the input change
        if (cfg.comp_en) begin
            comp_t = fixed_h + (dl - (dl >>> cfg.ratio));
        end else begin
            comp_t = fixed_h;
        end
        if (comp_t > max_h) begin
            comp_t = max_h;
        end
        lim_t = agc_pkg::agc_lvl_t'({3'h0, cfg.limit}) - lvl;
        if (cfg.lim_en && (lim_t < comp_t)) begin
            target = lim_t;
        end else begin
            target = comp_t;
        end
    end

    // Hold replaces release only right after a decrement
    always_comb begin
        if (after_dec_reg && cfg.hold_en && (cfg.hold > cfg.release_t)) begin
            up_iv = cfg.hold;
        end else begin
            up_iv = cfg.release_t;
        end
    end

    // Step decisions; a dead band keeps steady input quiet
    assign tracking = (state_reg == agc_pkg::AGC_TRACK) && cfg.agc_en && !cfg.shdn;
    assign gated = (level < cfg.gate);
    assign over_lim = cfg.lim_en && ((lvl + gain_x) > agc_pkg::agc_lvl_t'({3'h0, cfg.limit}));
    assign dec_want = (gain_x > (target + `AGC_DEADBAND)) && (gain_x > `AGC_GAIN_MIN);
    assign inc_want = (gain_x < (target - `AGC_DEADBAND)) && (gain_x < max_h);
    assign step_dn = tracking && !gated && dec_want
                     && (elapsed >= {1'b0, cfg.attack});
    assign step_up = tracking && !gated && !step_dn && inc_want
                     && (elapsed >= {1'b0, up_iv});

    // Mode sequencing around shutdown and enable
    always_comb begin
        case (state_reg)
            agc_pkg::AGC_SHUTDOWN: begin
                state_next = cfg.shdn ? agc_pkg::AGC_SHUTDOWN : agc_pkg::AGC_FIXED;
            end
            agc_pkg::AGC_FIXED: begin
                if (cfg.shdn) begin
                    state_next = agc_pkg::AGC_SHUTDOWN;
                end else if (cfg.agc_en) begin
                    state_next = agc_pkg::AGC_TRACK;
                end else begin
                    state_next = agc_pkg::AGC_FIXED;
                end
            end
            agc_pkg::AGC_TRACK: begin
                if (cfg.shdn) begin
                    state_next = agc_pkg::AGC_SHUTDOWN;
                end else if (!cfg.agc_en) begin
                    state_next = agc_pkg::AGC_FIXED;
                end else begin
                    state_next = agc_pkg::AGC_TRACK;
                end
            end
            default: state_next = agc_pkg::AGC_SHUTDOWN;
        endcase
    end

    // State and active flag
    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= agc_pkg::AGC_SHUTDOWN;
            active_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            active_reg <= (state_next == agc_pkg::AGC_TRACK);
        end
    end

    // Working gain: fixed when idle, half-dB steps when tracking
    always_ff @(posedge clk) begin
        if (reset) begin
            gain_reg <= `AGC_GAIN_RST;
        end else if (!tracking) begin
            gain_reg <= fixed_h[7:0];
        end else if (step_dn) begin
            gain_reg <= gain_reg - `AGC_STEP;
        end else if (step_up) begin
            gain_reg <= gain_reg + `AGC_STEP;
        end
    end

    // Step pulses and memory of the last direction
    always_ff @(posedge clk) begin
        if (reset) begin
            gain_up_reg <= 1'b0;
            gain_dn_reg <= 1'b0;
            after_dec_reg <= 1'b0;
        end else begin
            gain_up_reg <= step_up;
            gain_dn_reg <= step_dn;
            if (!tracking || step_up) begin
                after_dec_reg <= 1'b0;
            end else if (step_dn) begin
                after_dec_reg <= 1'b1;
            end
        end
    end

    // Checks on the steering behaviour
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_step_down_size: assert property (gain_dn_reg |-> gain_reg == $past(gain_reg) - 8'sh01)
        else $error("decrement not one half-dB step");
    a_step_up_size: assert property (gain_up_reg |-> gain_reg == $past(gain_reg) + 8'sh01)
        else $error("increment not one half-dB step");
    a_attack_space: assert property (gain_dn_reg |-> $past(elapsed) >= {1'b0, $past(attack_reg)})
        else $error("decrement before attack interval");
    a_release_space: assert property (gain_up_reg |-> $past(elapsed) >= {1'b0, $past(release_reg)})
        else $error("increment before release interval");
    a_hold_first_up: assert property ((gain_up_reg && $past(after_dec_reg) && $past(ctrl_reg[3])
        && ($past(hold_reg) > $past(release_reg))) |-> $past(elapsed) >= {1'b0, $past(hold_reg)})
        else $error("first increment before hold interval");
    a_fixed_load: assert property ((state_reg != agc_pkg::AGC_TRACK) |=>
        gain_reg == $past(fixed_h[7:0])) else $error("fixed gain not loaded while idle");
    a_gate_freeze: assert property ((level < gate_reg) |=> !gain_up_reg && !gain_dn_reg)
        else $error("gain moved below noise gate");
    a_gain_ceiling: assert property (gain_up_reg |-> gain_x <= $past(max_h))
        else $error("increment above maximum gain");
    a_timer_restart: assert property ((gain_up_reg || gain_dn_reg) |-> elapsed == '0)
        else $error("interval count not restarted after step");
    a_dec_priority: assert property (not (gain_up_reg && gain_dn_reg) ##0 1'b1)
        else $error("increment and decrement together");
    a_attack_block: assert property ((tracking && dec_want && (elapsed < {1'b0, attack_reg}))
        |=> !gain_dn_reg) else $error("decrement while attack running");

    c_gain_down: cover property (gain_dn_reg ##1 !gain_dn_reg [*3] ##1 gain_dn_reg);
    c_gain_up: cover property (gain_dn_reg ##[1:1000] gain_up_reg);
    c_gated: cover property (tracking && gated && dec_want);
    c_leave_shdn: cover property (state_reg == agc_pkg::AGC_SHUTDOWN ##1 state_reg == agc_pkg::AGC_FIXED);
endmodule
`default_nettype wire

//--- test/agc_host_model.sv
// Host model that programs the gain control block over its register port
`timescale 1ns/100ps
`default_nettype none
`include "agc_consts.svh"
module agc_host_model (
    input wire logic clk,
    input wire logic [31:0] reg_rdata,
    output logic [`AGC_ADDR_W-1:0] reg_addr,
    output logic [31:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    // Bus idle at time zero
    initial begin
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // One-cycle write; data is scrambled once the strobe is gone
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask
    // One-cycle read; data is taken in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

//--- test/tb_audio_agc_gain_controller.sv
// Self-checking testbench for the gain control core
`timescale 1ns/100ps
`default_nettype none
`include "agc_consts.svh"
module tb_audio_agc_gain_controller;
    localparam int ATK = 8; // Interval figures in cycles, one tick per cycle
    localparam int REL = 20;
    localparam int HLD = 60;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic smp_valid = 1'b0;
    logic signed [15:0] smp_data = '0;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata;
    logic [31:0] reg_rdata;
    logic reg_wr;
    logic reg_rd;
    logic signed [7:0] gain_half;
    logic gain_up;
    logic gain_dn;
    logic agc_active;
    int failures = 0;
    int checks = 0;
    int cyc = 0; // Cycle count and step history for the monitor
    int last_cyc = -1;
    int n_up = 0;
    int n_dn = 0;
    logic last_dn = 1'b0;
    logic signed [7:0] prev_gain = '0;
    logic [31:0] rv;

    always #4 clk = ~clk;

    agc_core #(.SMP_W(16), .TICK_CYCLES(1)) dut_u (.clk(clk), .reset(reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .smp_valid(smp_valid), .smp_data(smp_data),
        .gain_half(gain_half), .gain_up(gain_up), .gain_dn(gain_dn),
        .agc_active(agc_active));
    agc_host_model u_host (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

    // Compare and count
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Watches every step: size, exclusivity and spacing
    always @(posedge clk) begin
        cyc++;
        if (reset || !agc_active) begin
            last_cyc = -1;
        end else if (gain_up || gain_dn) begin
            check("step size", 32'(gain_half), 32'(gain_up ? prev_gain + 8'sd1 : prev_gain - 8'sd1));
            check("both steps", 32'(gain_up & gain_dn), 32'd0);
            if (last_cyc >= 0 && gain_dn && last_dn) begin
                check("attack gap", 32'(cyc - last_cyc >= ATK), 32'd1);
            end
            if (last_cyc >= 0 && gain_up && !last_dn) begin
                check("release gap", 32'(cyc - last_cyc >= REL), 32'd1);
            end
            if (last_cyc >= 0 && gain_up && last_dn) begin
                check("hold gap", 32'(cyc - last_cyc >= HLD), 32'd1);
            end
            n_up += int'(gain_up);
            n_dn += int'(gain_dn);
            last_dn = gain_dn;
            last_cyc = cyc;
        end
        prev_gain = gain_half;
    end

    // One sample per cycle for n cycles
    task automatic feed(input logic signed [15:0] v, input int n);
        repeat (n) begin
            @(posedge clk);
            smp_valid <= 1'b1;
            smp_data <= v;
        end
        @(posedge clk);
        smp_valid <= 1'b0;
    endtask

    // Reset values of every register except status, and an unmapped read
    task automatic t_reset_vals();
        logic [7:0] offs [10] = '{`AGC_OFF_CTRL, `AGC_OFF_FIXED, `AGC_OFF_MAXG,
            `AGC_OFF_LIMIT, `AGC_OFF_GATE, `AGC_OFF_RATIO, `AGC_OFF_ATTACK,
            `AGC_OFF_RELEASE, `AGC_OFF_HOLD, 8'h40};
        logic [31:0] exps [10] = '{32'(`AGC_CTRL_RST), 32'(`AGC_FIXED_RST),
            32'(`AGC_MAXG_RST), 32'(`AGC_LIMIT_RST), 32'(`AGC_GATE_RST),
            32'(`AGC_RATIO_RST), 32'(`AGC_ATTACK_RST), 32'(`AGC_RELEASE_RST),
            32'(`AGC_HOLD_RST), 32'h0};
        check("reset gain", 32'(gain_half), 32'(`AGC_GAIN_RST));
        for (int i = 0; i < 10; i++) begin
            u_host.rd(offs[i], rv);
            check("reset value", rv, exps[i]);
        end
    endtask

    // Fixed gain range depends on compression; then leave shutdown
    task automatic t_fixed();
        u_host.wr(`AGC_OFF_CTRL, 32'h10);
        u_host.wr(`AGC_OFF_FIXED, 32'hfb); // Minus 5 dB as a signed byte
        u_host.rd(`AGC_OFF_FIXED, rv);
        check("fixed floor lin", {26'h0, rv[5:0]}, 32'h0);
        u_host.wr(`AGC_OFF_CTRL, 32'h12);
        u_host.wr(`AGC_OFF_FIXED, 32'he4); // Minus 28 dB as a signed byte
        u_host.rd(`AGC_OFF_FIXED, rv);
        check("fixed floor comp", {26'h0, rv[5:0]}, 32'h24);
        u_host.wr(`AGC_OFF_ATTACK, 32'(ATK));
        u_host.wr(`AGC_OFF_RELEASE, 32'(REL));
        u_host.wr(`AGC_OFF_HOLD, 32'(HLD));
        u_host.wr(`AGC_OFF_MAXG, 32'h8);
        u_host.wr(`AGC_OFF_FIXED, 32'h6);
        u_host.wr(`AGC_OFF_CTRL, 32'h0b);
        repeat (3) @(posedge clk);
        check("gain out of shutdown", 32'(gain_half), 32'h0c);
        check("tracking", 32'(agc_active), 32'h1);
    endtask

    // Quiet input below the gate leaves gain frozen
    task automatic t_gate();
        int u0;
        u0 = n_up;
        feed(16'sh0001, 150);
        check("gated gain", 32'(gain_half), 32'h0c);
        check("gated steps", 32'(n_up - u0), 32'h0);
    endtask

    // Moderate input raises gain to one half-dB step under the maximum and no further
    task automatic t_raise();
        int u0;
        u0 = n_up;
        feed(16'sh0100, 300);
        check("raised", 32'(n_up - u0 >= 2), 32'h1);
        // Dead band leaves the gain one half-dB step under the cap
        check("max cap", 32'(gain_half), 32'h0f);
    endtask

    // Loud input drops at once, then once per attack interval
    task automatic t_attack();
        int d0;
        d0 = n_dn;
        feed(16'sh7d00, 6);
        check("first drop", 32'(n_dn > d0), 32'h1);
        feed(16'sh7d00, 100);
        check("later drops", 32'(n_dn - d0 >= 3), 32'h1);
    endtask

    // After a fall in level, gain returns by hold then release
    task automatic t_recover();
        int u0;
        u0 = n_up;
        feed(16'sh0100, 3000);
        check("recovered", 32'(n_up > u0), 32'h1);
        check("recover cap", 32'(gain_half), 32'h0f);
    endtask

    // Limiter caps gain at limit minus level; status shows the result
    task automatic t_limit();
        int d0;
        // Steady envelope of 255 gives a level of 105
        feed(16'sh00ff, 4);
        d0 = n_dn;
        u_host.wr(`AGC_OFF_LIMIT, 32'h73);
        u_host.wr(`AGC_OFF_CTRL, 32'h0f);
        repeat (60) @(posedge clk);
        // Target 115 - 105 = 10; dead band stops one step above it
        check("limit gain", 32'(gain_half), 32'h0b);
        check("limit drops", 32'(n_dn - d0), 32'h4);
        u_host.rd(`AGC_OFF_STATUS, rv);
        check("status gain", {24'h0, rv[7:0]}, 32'h0b);
        check("status level", {24'h0, rv[15:8]}, 32'h69);
        check("status flags", {30'h0, rv[18], rv[16]}, 32'h2);
    endtask

    // Disabling the control reloads the fixed gain
    task automatic t_disable();
        u_host.wr(`AGC_OFF_CTRL, 32'h02);
        repeat (3) @(posedge clk);
        check("fixed reload", 32'(gain_half), 32'h0c);
        check("inactive", 32'(agc_active), 32'h0);
    endtask

    // Prints counts and the verdict, then ends the run
    task automatic print_verdict();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Cuts a hang short
    initial begin
        #200000;
        failures++;
        print_verdict();
    end

    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_reset_vals();
        t_fixed();
        t_gate();
        t_raise();
        t_attack();
        t_recover();
        t_limit();
        t_disable();
        print_verdict();
    end
endmodule
`default_nettype wire
